// ---- bench/ldrpb_dec_model.sv ----
// Model of the command decoder that feeds the display memory.
// Assumes the bench clock; drives 1 ns after each rising edge.
`timescale 1ns/1ps
module ldrpb_dec_model
  import ldrpb_pkg::*;
(
  input wire logic i_clk,
  output ldrpb_cmd_t o_cmd,
  output logic o_byte_valid,
  output logic [7:0] o_byte
);
  // Idle at time zero
  initial
  begin
    o_cmd = '0;
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // One-cycle command pulse
  task automatic cmd(input ldrpb_cmd_t c);
    @(posedge i_clk);
    #1;
    o_cmd = c;
    @(posedge i_clk);
    #1;
    o_cmd = '0;
  endtask
  // Byte strobe, held for back-to-back when gap is zero
  task automatic put(input logic [7:0] b, input int gap);
    @(posedge i_clk);
    #1;
    o_byte_valid = 1'b1;
    o_byte = b;
    if (gap > 0)
    begin
      @(posedge i_clk);
      #1;
      o_byte_valid = 1'b0;
      o_byte = ~b; // Released data never repeats
      repeat (gap - 1) @(posedge i_clk);
    end
  endtask
  // End of a burst
  task automatic idle();
    @(posedge i_clk);
    #1;
    o_byte_valid = 1'b0;
    o_byte = ~o_byte;
  endtask
endmodule

// ---- bench/tb_top.sv ----
// Bench for the display RAM, pointer and bank block.
// Assumes the decoder model drives all byte and command inputs.
`timescale 1ns/1ps
module tb_top;
  import ldrpb_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  ldrpb_mode_t i_mode = LDRPB_MUX8;
  ldrpb_cmd_t i_cmd;
  logic i_byte_valid;
  logic [7:0] i_byte;
  logic [59:0] o_segment_out;
  logic [7:0] o_backplane_out;
  logic [5:0] o_ptr;
  logic [2:0] o_in_bank;
  logic [2:0] o_out_bank;
  logic [7:0] mem [60];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 5;
  int col = 0;
  int row = 0;
  int m_in = 0;
  int m_out = 0;
  // Clock
  always #50 i_clk = ~i_clk;
  ldrpb_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_mode(i_mode), .i_cmd(i_cmd), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .o_segment_out(o_segment_out), .o_backplane_out(o_backplane_out), .o_ptr(o_ptr),
    .o_in_bank(o_in_bank), .o_out_bank(o_out_bank));
  ldrpb_dec_model u_dec (.i_clk(i_clk), .o_cmd(i_cmd), .o_byte_valid(i_byte_valid), .o_byte(i_byte));
  ////////////////////////////////////////////////////////////
  // Verdict and comparisons
  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_st(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_seg(input logic [59:0] got, input logic [59:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////
  // Expected RAM fill, MSB first into rows then columns
  task automatic model_byte(input logic [7:0] b);
    int n;
    int off;
    n = (i_mode == LDRPB_MUX6) ? 6 : (i_mode == LDRPB_MUX8) ? 8 : (1 << i_mode);
    off = (i_mode < LDRPB_MUX6) ? m_in : 0;
    for (int i = 7; i >= 0; i--)
    begin
      if (col < 60)
        mem[col][off + row] = b[i];
      row++;
      if (row == n)
      begin
        row = 0;
        col++;
      end
      if (col == 60 && n > 1)
        col = 0;
    end
    if (col >= 60)
      col = 0;
  endtask
  // Display samples against the model, inversion read off the backplanes
  task automatic chk_disp();
    logic [7:0] oh;
    logic inv;
    logic [59:0] e;
    int r;
    int off;
    off = (i_mode < LDRPB_MUX6) ? m_out : 0;
    repeat (1700) @(posedge i_clk);
    repeat (40)
    begin
      repeat (37) @(posedge i_clk);
      #2;
      inv = $countones(o_backplane_out) > 4;
      oh = inv ? ~o_backplane_out : o_backplane_out;
      chk_st(6'($countones(oh)), 6'h01);
      if ($countones(oh) == 1)
      begin
        for (int k = 0; k < 8; k++)
          if (oh[k])
            r = k;
        for (int c = 0; c < 60; c++)
          e[c] = mem[c][r + off] ^ inv;
        chk_seg(o_segment_out, e);
      end
    end
  endtask
  // Mode, banks for static, 1:2 and 1:4 only, pointer, then a random burst
  task automatic run(input int md, input int inb, input int outb, input int start, input int n, input int gap);
    ldrpb_cmd_t c;
    logic [7:0] b;
    @(posedge i_clk);
    #1;
    i_mode = ldrpb_mode_t'(md);
    if (md < 3)
    begin
      c = '0;
      c.bank_value = 3'(inb);
      c.in_bank_load = 1'b1;
      u_dec.cmd(c);
      c.in_bank_load = 1'b0;
      c.out_bank_load = 1'b1;
      c.bank_value = 3'(outb);
      u_dec.cmd(c);
      m_in = (md == 0) ? inb : inb & ((md == 1) ? 6 : 4);
      m_out = (md == 0) ? outb : outb & ((md == 1) ? 6 : 4);
      repeat (3) @(posedge i_clk);
      chk_st({3'h0, o_in_bank}, 6'(m_in));
      chk_st({3'h0, o_out_bank}, 6'(m_out));
    end
    c = '0;
    c.ptr_load = 1'b1;
    c.ptr_value = 6'(start);
    col = (start > 59) ? 0 : start;
    row = 0;
    u_dec.cmd(c);
    repeat (3) @(posedge i_clk);
    chk_st(o_ptr, 6'(col));
    for (int k = 0; k < n; k++)
    begin
      b = 8'($random(seed));
      model_byte(b);
      u_dec.put(b, gap);
      if (gap > 0)
        chk_st(o_ptr, 6'(col));
    end
    u_dec.idle();
    repeat (3) @(posedge i_clk);
    chk_st(o_ptr, 6'(col));
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge i_clk);
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    repeat (2) @(posedge i_clk);
    chk_st(o_ptr, 6'h00);
    chk_st({o_in_bank, o_out_bank}, 6'h00);
    run(4, 0, 0, 0, 60, 0);
    chk_disp();
    run(3, 0, 0, 62, 45, 3);
    chk_disp();
    run(0, 3, 3, 0, 8, 0);
    chk_disp();
    run(0, 5, 1, 56, 1, 3);
    chk_disp();
    run(2, 5, 7, 59, 30, 0);
    chk_disp();
    run(1, 3, 6, 58, 15, 3);
    chk_disp();
    repeat (4)
    begin
      run($unsigned($random(seed)) % 5, $unsigned($random(seed)) % 8, $unsigned($random(seed)) % 8,
        $unsigned($random(seed)) % 64, 1 + $unsigned($random(seed)) % 20, 0);
      chk_disp();
    end
    end_sim();
  end
endmodule

// ---- core/ldrpb_pkg.sv ----
// Package for the display RAM, pointer and bank block.
// Assumes a single clock domain and synchronous reset.
package ldrpb_pkg;
  localparam int LDRPB_COLS = 60;
  localparam int LDRPB_ROWS = 8;
  localparam logic [5:0] LDRPB_LAST_COL = 6'h3B;
  localparam logic [5:0] LDRPB_PTR_RST = 6'h00;
  localparam logic [2:0] LDRPB_BANK_RST = 3'h0;
  // Frame: one row per phase, phase time of 100 cycles
  localparam int LDRPB_PHASE_US = 10;
  localparam int LDRPB_CLK_MHZ = 10;
  localparam int LDRPB_PHASE_CYC = LDRPB_PHASE_US * LDRPB_CLK_MHZ;
  localparam logic [6:0] LDRPB_PHASE_LAST = 7'(LDRPB_PHASE_CYC - 1);

  // Multiplex drive modes
  typedef enum logic [2:0] {
    LDRPB_STATIC = 3'b000,
    LDRPB_MUX2 = 3'b001,
    LDRPB_MUX4 = 3'b010,
    LDRPB_MUX6 = 3'b011,
    LDRPB_MUX8 = 3'b100
  } ldrpb_mode_t;

  // Commands from the command decoder
  typedef struct packed {
    logic ptr_load;
    logic [5:0] ptr_value;
    logic in_bank_load;
    logic out_bank_load;
    logic [2:0] bank_value;
  } ldrpb_cmd_t;

  // One RAM write: column, row mask and row data
  typedef struct packed {
    logic en;
    logic [5:0] col;
    logic [7:0] mask;
    logic [7:0] data;
  } ldrpb_wr_t;
endpackage

// ---- core/ldrpb_ram.sv ----
// Display RAM, 60 columns by 8 rows, eight single-bit write ports.
// Assumes write and read ports driven from the same clock.
`timescale 1ns/1ps
module ldrpb_ram
  import ldrpb_pkg::*;
#(
  parameter int COLS = 60,
  parameter int ROWS = 8
)
(
  input wire logic i_clk,
  input wire ldrpb_wr_t [7:0] i_wr,
  input wire logic [2:0] i_rd_row,
  output logic [COLS-1:0] o_rd_row
);
  logic [ROWS-1:0] mem [COLS];

  ////////////////////////////////////////////////////////////////
  // One port per byte bit, so a byte may touch up to eight columns
  always_ff @(posedge i_clk)
  begin
    for (int j = 0; j < 8; j++)
    begin
      for (int r = 0; r < ROWS; r++)
      begin
        if (i_wr[j].en && i_wr[j].col < 6'(COLS) && i_wr[j].mask[r])
          mem[i_wr[j].col][r] <= i_wr[j].data[r];
      end
    end
    // Registered read of one whole row across all columns
    for (int c = 0; c < COLS; c++)
      o_rd_row[c] <= mem[c][i_rd_row];
  end
endmodule

// ---- core/ldrpb_seg.sv ----
// One segment output stage: display bit against the active row.
// Assumes the row select and display bit are stable per phase.
`timescale 1ns/1ps
module ldrpb_seg
  import ldrpb_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_bit,
  input wire logic i_phase_inv,
  output logic o_seg
);
  logic next_seg;

  ////////////////////////////////////////////////////////////////
  // Segment level is the display bit, inverted on odd frames
  always_comb
  begin
    next_seg = i_bit ^ i_phase_inv;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_seg <= 1'b0;
    else
      o_seg <= next_seg;
  end
endmodule

// ---- core/ldrpb_top.sv ----
// Display memory with data pointer, bank selects and display register.
// Assumes bytes and commands arrive as one-cycle strobes from the decoder.
`timescale 1ns/1ps
module ldrpb_top
  import ldrpb_pkg::*;
#(
  parameter int COLS = 60,
  parameter int ROWS = 8
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire ldrpb_mode_t i_mode,
  input wire ldrpb_cmd_t i_cmd,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic [COLS-1:0] o_segment_out,
  output logic [ROWS-1:0] o_backplane_out,
  output logic [5:0] o_ptr,
  output logic [2:0] o_in_bank,
  output logic [2:0] o_out_bank
);
  logic [5:0] ptr;
  logic [2:0] sub;
  logic [2:0] in_bank;
  logic [2:0] out_bank;
  logic [5:0] next_ptr;
  logic [2:0] next_sub;
  logic [2:0] next_in_bank;
  logic [2:0] next_out_bank;
  ldrpb_wr_t [7:0] wr;
  logic [2:0] nrows;
  logic [2:0] band;
  logic [2:0] ob_mask;

  ////////////////////////////////////////////////////////////////
  // Rows per column and bank alignment per mode
  always_comb
  begin
    nrows = 3'd0;
    ob_mask = 3'd0;
    case (i_mode)
      LDRPB_STATIC:
      begin
        nrows = 3'd1;
        ob_mask = 3'b111;
      end
      LDRPB_MUX2:
      begin
        nrows = 3'd2;
        ob_mask = 3'b110;
      end
      LDRPB_MUX4:
      begin
        nrows = 3'd4;
        ob_mask = 3'b100;
      end
      LDRPB_MUX6:
      begin
        nrows = 3'd6;
        ob_mask = 3'b000;
      end
      default:
      begin
        nrows = 3'd0;
        ob_mask = 3'b000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Byte packing: one write port per bit, columns and rows from pointer
  always_comb
  begin
    logic [5:0] col;
    logic [2:0] row;
    logic [5:0] adv;
    wr = '0;
    col = ptr;
    row = sub;
    adv = 6'd0;
    next_ptr = ptr;
    next_sub = sub;
    band = (i_mode == LDRPB_MUX8 || i_mode == LDRPB_MUX6) ? 3'd0 : in_bank;
    if (i_byte_valid)
    begin
      for (int i = 0; i < 8; i++)
      begin
        wr[i].data = {8{i_byte[7 - i]}};
        if (i_mode == LDRPB_MUX8)
        begin
          wr[i].en = 1'b1;
          wr[i].col = ptr;
          wr[i].mask = 8'(8'h01 << i);
        end
        else if (i_mode == LDRPB_STATIC)
        begin
          // one row, bits past the last column dropped
          wr[i].en = (7'(ptr) + 7'(i)) <= 7'(LDRPB_LAST_COL);
          wr[i].col = 6'(ptr + 6'(i));
          wr[i].mask = 8'(8'h01 << band);
        end
        else
        begin
          // wrapped bits land in the input bank
          wr[i].en = 1'b1;
          wr[i].col = col;
          wr[i].mask = 8'(8'h01 << (row + band));
          if (row + 3'd1 == nrows)
          begin
            row = 3'd0;
            col = (col == LDRPB_LAST_COL) ? 6'd0 : col + 6'd1;
          end
          else
            row = row + 3'd1;
        end
      end
      if (i_mode == LDRPB_MUX8)
        next_ptr = (ptr == LDRPB_LAST_COL) ? 6'd0 : ptr + 6'd1;
      else if (i_mode == LDRPB_STATIC)
      begin
        adv = ptr + 6'd8;
        next_ptr = (adv > LDRPB_LAST_COL || ptr > LDRPB_LAST_COL - 6'd8) ? 6'd0 : adv;
      end
      else
      begin
        next_ptr = col;
        next_sub = row;
      end
    end
    if (i_cmd.ptr_load)
    begin
      next_ptr = (i_cmd.ptr_value > LDRPB_LAST_COL) ? 6'd0 : i_cmd.ptr_value;
      next_sub = 3'd0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Bank selects, masked to the mode's bank alignment, cleared to 0 by a load in bankless modes
  always_comb
  begin
    next_in_bank = in_bank;
    next_out_bank = out_bank;
    if (i_cmd.in_bank_load)
      next_in_bank = i_cmd.bank_value & ob_mask;
    if (i_cmd.out_bank_load)
      next_out_bank = i_cmd.bank_value & ob_mask;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ptr <= LDRPB_PTR_RST;
      sub <= 3'd0;
      in_bank <= LDRPB_BANK_RST;
      out_bank <= LDRPB_BANK_RST;
    end
    else
    begin
      ptr <= next_ptr;
      sub <= next_sub;
      in_bank <= next_in_bank;
      out_bank <= next_out_bank;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Frame timing: row phase counter and backplane select
  logic [6:0] tick;
  logic [2:0] phase;
  logic inv;
  logic [6:0] next_tick;
  logic [2:0] next_phase;
  logic next_inv;
  logic [2:0] nph;
  always_comb
  begin
    nph = (nrows == 3'd0) ? 3'd7 : nrows - 3'd1;
    next_tick = (tick == LDRPB_PHASE_LAST) ? 7'd0 : tick + 7'd1;
    next_phase = phase;
    next_inv = inv;
    if (tick == LDRPB_PHASE_LAST)
    begin
      next_phase = (phase >= nph) ? 3'd0 : phase + 3'd1;
      if (phase >= nph)
        next_inv = ~inv;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      tick <= 7'd0;
      phase <= 3'd0;
      inv <= 1'b0;
    end
    else
    begin
      tick <= next_tick;
      phase <= next_phase;
      inv <= next_inv;
    end
  end

  ////////////////////////////////////////////////////////////////
  // display register latched at phase start
  logic [COLS-1:0] dreg;
  logic [COLS-1:0] next_dreg;
  logic [2:0] rd_row;
  logic [COLS-1:0] ram_row;
  // Row of the coming phase, read one cycle ahead of the load
  always_comb
  begin
    rd_row = ((phase >= nph) ? 3'd0 : phase + 3'd1) + ((i_mode == LDRPB_MUX8 || i_mode == LDRPB_MUX6) ? 3'd0 : out_bank);
    next_dreg = dreg;
    if (tick == LDRPB_PHASE_LAST)
      next_dreg = ram_row;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      dreg <= '0;
    else
      dreg <= next_dreg;
  end

  ////////////////////////////////////////////////////////////////
  // memory array, sixty columns by eight rows
  // column to segment, row to backplane
  ldrpb_ram #(
    .COLS(COLS),
    .ROWS(ROWS)
  ) u_ram (
    .i_clk(i_clk),
    .i_wr(wr),
    .i_rd_row(rd_row),
    .o_rd_row(ram_row)
  );

  ////////////////////////////////////////////////////////////////
  // segment drivers
  for (genvar g = 0; g < COLS; g++)
  begin : g_seg
    ldrpb_seg u_seg (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_bit(dreg[g]),
      .i_phase_inv(inv),
      .o_seg(o_segment_out[g])
    );
  end

  ////////////////////////////////////////////////////////////////
  // Backplane one-hot of active phase, inverted on odd frames, status outputs
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_backplane_out <= '0;
      o_ptr <= '0;
      o_in_bank <= '0;
      o_out_bank <= '0;
    end
    else
    begin
      o_backplane_out <= ROWS'(8'h01 << phase) ^ {ROWS{inv}};
      o_ptr <= ptr;
      o_in_bank <= in_bank;
      o_out_bank <= out_bank;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  AST_PTR_LOAD: assert property (@(posedge i_clk) disable iff (i_srst)
    i_cmd.ptr_load && i_cmd.ptr_value <= LDRPB_LAST_COL |=> ptr == $past(i_cmd.ptr_value))
    else $error("pointer load not taken");
  AST_STEP8: assert property (@(posedge i_clk) disable iff (i_srst)
    i_byte_valid && !i_cmd.ptr_load && i_mode == LDRPB_MUX8 && ptr < LDRPB_LAST_COL |=> ptr == $past(ptr) + 6'd1)
    else $error("1:8 step wrong");
  AST_WRAP: assert property (@(posedge i_clk) disable iff (i_srst)
    i_byte_valid && !i_cmd.ptr_load && i_mode == LDRPB_MUX8 && ptr == LDRPB_LAST_COL |=> ptr == 6'd0)
    else $error("no wrap");
  AST_PTR_RANGE: assert property (@(posedge i_clk) disable iff (i_srst)
    ptr <= LDRPB_LAST_COL)
    else $error("pointer out of range");
  AST_BANK_ALIGN: assert property (@(posedge i_clk) disable iff (i_srst)
    i_cmd.in_bank_load && i_mode == LDRPB_MUX4 |=> in_bank[1:0] == 2'b00)
    else $error("bank misaligned");
  AST_IND_BANK: assert property (@(posedge i_clk) disable iff (i_srst)
    i_cmd.in_bank_load && !i_cmd.out_bank_load |=> $stable(out_bank))
    else $error("banks not independent");
  AST_DREG_HOLD: assert property (@(posedge i_clk) disable iff (i_srst)
    tick != LDRPB_PHASE_LAST |=> $stable(dreg))
    else $error("display register moved");
  AST_RESET: assert property (@(posedge i_clk) i_srst |=> ptr == 6'd0 && out_bank == 3'd0)
    else $error("reset values");
  AST_STEP_ST: assert property (@(posedge i_clk) disable iff (i_srst)
    i_byte_valid && !i_cmd.ptr_load && i_mode == LDRPB_STATIC && ptr <= LDRPB_LAST_COL - 6'd8
    |=> ptr == $past(ptr) + 6'd8)
    else $error("static step wrong");
  AST_WRAP_ST: assert property (@(posedge i_clk) disable iff (i_srst)
    i_byte_valid && !i_cmd.ptr_load && i_mode == LDRPB_STATIC && ptr > LDRPB_LAST_COL - 6'd8 |=> ptr == 6'd0)
    else $error("static wrap missing");
  AST_NO_BANK: assert property (@(posedge i_clk) disable iff (i_srst)
    i_cmd.in_bank_load && (i_mode == LDRPB_MUX6 || i_mode == LDRPB_MUX8) |=> in_bank == 3'd0)
    else $error("bank taken in bankless mode");
  AST_BP_ONEHOT: assert property (@(posedge i_clk) disable iff (i_srst)
    !$past(i_srst) |-> $onehot(o_backplane_out) || $onehot(~o_backplane_out))
    else $error("backplane not one row");
endmodule
